// file: hw/sfr_dev.sv
// flash end: command decode and read data shifter
`timescale 1ns/1ps
`default_nettype none
module sfr_dev import sfr_pkg::*; #(
   parameter logic [7:0] OP_READ = SFR_OP_READ,
   parameter logic [7:0] OP_FAST = SFR_OP_FAST,
   parameter logic [7:0] OP_DUAL = SFR_OP_DUAL,
   parameter logic [7:0] OP_LOCK = SFR_OP_LOCK,
   parameter logic [7:0] OP_OTP  = SFR_OP_OTP
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   sfr_link_if.dev          lk,
   input  wire logic        busy,
   output logic [22:0]      mem_addr,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        lock_we,
   input  wire logic [6:0]  lock_sector,
   input  wire logic [7:0]  lock_wdata,
   input  wire logic [6:0]  prot_sector,
   output logic             prot_deny,
   input  wire logic        otp_we,
   input  wire logic [6:0]  otp_idx,
   input  wire logic [7:0]  otp_wdata
);
   typedef enum logic [2:0] {
      D_CMD, D_ADDR, D_DUMMY, D_DATA, D_IGNORE
   } sfr_dph_type;

   typedef struct packed {
      logic [2:0]   sck_s;
      logic [2:0]   cs_s;
      logic [2:0]   d0_s;
      logic         sck_f;
      logic         cs_f;
      logic         d0_f;
      sfr_dph_type  ph;
      sfr_mode_type mode;
      logic [7:0]   op;
      logic [5:0]   cnt;
      logic [23:0]  addr;
      logic [7:0]   osr;
      logic [3:0]   bits;
      logic [1:0]   fetch;
      logic         io0;
      logic         io0_oe;
      logic         io1;
      logic         io1_oe;
      logic [22:0]  mem_addr;
      logic         deny;
   } sfr_dev_st_type;

   sfr_dev_st_type r_reg;
   sfr_dev_st_type r_next;
   logic [7:0] lock_mem [128];
   logic [7:0] otp_mem [65];
   logic       rise;
   logic       fall;
   logic [7:0] op_n;
   logic [6:0] otp_rd;
   logic [7:0] src;

   // one-time area index never passes the control byte
   assign otp_rd = (r_reg.addr[6:0] > SFR_OTP_LAST) ? SFR_OTP_LAST
                   : r_reg.addr[6:0]; // RULE15
   // byte source for the current read mode
   always_comb begin
      unique case (r_reg.mode)
         SFR_M_LOCK: src = lock_mem[r_reg.addr[SFR_SEC_MSB:SFR_SEC_LSB]]
                           & SFR_LOCK_MASK; // RULE10 RULE17
         SFR_M_OTP:  src = otp_mem[otp_rd]; // RULE13
         default:    src = mem_rdata;
      endcase
   end

   // pin filtering, command decode, data shifting
   always_comb begin
      r_next = r_reg;
      op_n = {r_reg.op[6:0], r_reg.d0_f};
      r_next.sck_s = {r_reg.sck_s[1:0], lk.sck};
      r_next.cs_s = {r_reg.cs_s[1:0], lk.cs_n};
      r_next.d0_s = {r_reg.d0_s[1:0], lk.io0};
      if (r_reg.sck_s[1] == r_reg.sck_s[2])
         r_next.sck_f = r_reg.sck_s[2];
      if (r_reg.cs_s[1] == r_reg.cs_s[2])
         r_next.cs_f = r_reg.cs_s[2];
      if (r_reg.d0_s[1] == r_reg.d0_s[2])
         r_next.d0_f = r_reg.d0_s[2];
      rise = r_next.sck_f & ~r_reg.sck_f;
      fall = ~r_next.sck_f & r_reg.sck_f;
      r_next.deny = lock_mem[prot_sector][SFR_WLOCK_BIT]; // RULE12
      // fetch pipeline: address out, data back, load shifter
      if (r_reg.fetch == 2'd2) begin
         r_next.fetch = 2'd1;
      end else if (r_reg.fetch == 2'd1) begin
         r_next.fetch = 2'd0;
         r_next.osr = src;
         r_next.bits = 4'd8;
      end
      if (r_reg.cs_f) begin
         // deselected: release lines and rearm
         r_next.ph = D_CMD; // RULE6
         r_next.cnt = 6'd0;
         r_next.fetch = 2'd0;
         r_next.io0_oe = 1'b0;
         r_next.io1_oe = 1'b0;
      end else if (rise) begin
         unique case (r_reg.ph)
            D_CMD: begin
               r_next.op = op_n; // RULE1
               r_next.cnt = r_reg.cnt + 6'd1;
               if (r_reg.cnt == 6'd7) begin
                  r_next.cnt = 6'd0;
                  r_next.ph = D_ADDR;
                  if (op_n == OP_READ)
                     r_next.mode = SFR_M_READ;
                  else if (op_n == OP_FAST)
                     r_next.mode = SFR_M_FAST;
                  else if (op_n == OP_DUAL)
                     r_next.mode = SFR_M_DUAL;
                  else if (op_n == OP_LOCK)
                     r_next.mode = SFR_M_LOCK;
                  else if (op_n == OP_OTP)
                     r_next.mode = SFR_M_OTP;
                  else
                     r_next.ph = D_IGNORE;
                  if (busy)
                     r_next.ph = D_IGNORE; // RULE7
               end
            end
            D_ADDR: begin
               r_next.addr = {r_reg.addr[22:0], r_reg.d0_f}; // RULE1 RULE3
               r_next.cnt = r_reg.cnt + 6'd1;
               if (r_reg.cnt == 6'd23) begin
                  r_next.cnt = 6'd0;
                  if (r_reg.mode == SFR_M_READ
                      || r_reg.mode == SFR_M_LOCK) begin
                     r_next.ph = D_DATA;
                     r_next.fetch = 2'd2;
                     r_next.mem_addr = r_next.addr[22:0]; // RULE5
                  end else begin
                     r_next.ph = D_DUMMY; // RULE8 RULE13
                  end
               end
            end
            D_DUMMY: begin
               r_next.cnt = r_reg.cnt + 6'd1;
               if (r_reg.cnt == 6'd7) begin
                  r_next.ph = D_DATA; // RULE8
                  r_next.fetch = 2'd2;
                  r_next.mem_addr = r_reg.addr[22:0]; // RULE5
               end
            end
            default: begin
               r_next.cnt = r_reg.cnt;
            end
         endcase
      end else if (fall && r_reg.ph == D_DATA) begin
         r_next.io1 = r_reg.osr[7]; // RULE2 RULE16
         r_next.io1_oe = 1'b1;
         if (r_reg.mode == SFR_M_DUAL) begin
            r_next.io0 = r_reg.osr[6]; // RULE9 RULE16
            r_next.io0_oe = 1'b1;
            r_next.osr = {r_reg.osr[5:0], 2'b00};
            r_next.bits = r_reg.bits - 4'd2;
         end else begin
            r_next.osr = {r_reg.osr[6:0], 1'b0};
            r_next.bits = r_reg.bits - 4'd1;
         end
         if (r_next.bits == 4'd0) begin
            // byte done: step the address (lock reads hold it, as do one-time reads at the last byte) and refill
            r_next.fetch = 2'd2;
            unique case (r_reg.mode)
               SFR_M_LOCK: r_next.addr = r_reg.addr;
               SFR_M_OTP: begin
                  if (otp_rd < SFR_OTP_LAST)
                     r_next.addr = r_reg.addr + 24'd1; // RULE14
               end
               default: begin
                  r_next.addr = {1'b0, r_reg.addr[22:0] + 23'd1}; // RULE4
               end
            endcase
            r_next.mem_addr = r_next.addr[22:0];
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.sck_s <= 3'h0;
         r_reg.cs_s <= 3'h7;
         r_reg.cs_f <= 1'b1;
         r_reg.ph <= D_CMD;
         r_reg.mode <= SFR_M_READ;
      end else begin
         r_reg <= r_next;
      end
   end

   // sector lock bytes, cleared by reset, written with the masked data while lock-down is clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < 128; i++)
            lock_mem[i] <= 8'h00;
      end else if (lock_we
                   && !lock_mem[lock_sector][SFR_LOCKDN_BIT]) begin
         lock_mem[lock_sector] <= lock_wdata & SFR_LOCK_MASK; // RULE11
      end
   end

   // one-time area programs bits only toward zero
   always_ff @(posedge clk) begin
      if (otp_we && otp_idx <= SFR_OTP_LAST)
         otp_mem[otp_idx] <= otp_mem[otp_idx] & otp_wdata;
   end

   assign lk.d_io0 = r_reg.io0;
   assign lk.d_io0_oe = r_reg.io0_oe;
   assign lk.d_io1 = r_reg.io1;
   assign lk.d_io1_oe = r_reg.io1_oe;
   assign mem_addr = r_reg.mem_addr;
   assign prot_deny = r_reg.deny;
endmodule : sfr_dev
`default_nettype wire

// file: hw/sfr_host.sv
// host end: register port, serial clock master, receive fifo
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sfr_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } sfr_fifo_st_type;
   sfr_fifo_st_type r_reg;
   sfr_fifo_st_type r_next;
   logic [W-1:0] mem [D];
   logic         push;
   logic         pop;

   assign in_ready = r_reg.cnt < (AW+1)'(D);
   assign out_valid = r_reg.cnt != '0;
   assign out_data = mem[r_reg.rp];
   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;

   // pointer and level update
   always_comb begin
      r_next = r_reg;
      if (push)
         r_next.wp = (r_reg.wp == AW'(D-1)) ? '0 : r_reg.wp + 1'b1;
      if (pop)
         r_next.rp = (r_reg.rp == AW'(D-1)) ? '0 : r_reg.rp + 1'b1;
      r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
      if (push)
         mem[r_reg.wp] <= in_data;
   end
endmodule : sfr_fifo

module sfr_host import sfr_pkg::*; #(
   parameter int HALF = SFR_HALF_CYC,
   parameter logic [7:0] OP_READ = SFR_OP_READ,
   parameter logic [7:0] OP_FAST = SFR_OP_FAST,
   parameter logic [7:0] OP_DUAL = SFR_OP_DUAL,
   parameter logic [7:0] OP_LOCK = SFR_OP_LOCK,
   parameter logic [7:0] OP_OTP  = SFR_OP_OTP
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   sfr_link_if.host         lk,
   input  wire logic [4:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata
);
   typedef enum logic [1:0] {H_IDLE, H_RUN} sfr_hph_type;
   typedef struct packed {
      sfr_hph_type ph;
      logic [7:0]  div;
      logic        sck;
      logic        cs_n;
      logic        io0;
      logic        io0_oe;
      logic [39:0] tx;
      logic [5:0]  cnt;
      logic [5:0]  hdr;
      logic        dual;
      logic [15:0] left;
      logic        done;
      logic [7:0]  rx;
      logic [3:0]  rxn;
      logic        push;
      logic [7:0]  rxb;
      logic [2:0]  i0_s;
      logic [2:0]  i1_s;
      logic        i0_f;
      logic        i1_f;
      logic [23:0] a;
      logic [15:0] len;
      logic [31:0] rdata;
   } sfr_host_st_type;
   sfr_host_st_type r_reg;
   sfr_host_st_type r_next;
   logic         f_ready;
   logic         f_valid;
   logic [7:0]   f_data;
   logic         pop;
   logic [7:0]   opc;
   sfr_mode_type md;

   assign md = sfr_mode_type'(wdata[2:0]);
   assign pop = rd && addr == SFR_R_DATA;

   // opcode for a requested mode
   always_comb begin
      unique case (md)
         SFR_M_FAST: opc = OP_FAST;
         SFR_M_DUAL: opc = OP_DUAL;
         SFR_M_LOCK: opc = OP_LOCK;
         SFR_M_OTP:  opc = OP_OTP;
         default:    opc = OP_READ;
      endcase
   end

   sfr_fifo #(.W(8), .D(SFR_FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (r_reg.push),
      .in_ready  (f_ready),
      .in_data   (r_reg.rxb),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data)
   );

   // register port, clock divider, frame sequencing
   always_comb begin
      r_next = r_reg;
      r_next.i0_s = {r_reg.i0_s[1:0], lk.io0};
      r_next.i1_s = {r_reg.i1_s[1:0], lk.io1};
      if (r_reg.i0_s[1] == r_reg.i0_s[2])
         r_next.i0_f = r_reg.i0_s[2];
      if (r_reg.i1_s[1] == r_reg.i1_s[2])
         r_next.i1_f = r_reg.i1_s[2];
      if (r_reg.push && f_ready)
         r_next.push = 1'b0;
      // register reads, data one cycle later
      r_next.rdata = 32'h0;
      if (rd) begin
         unique case (addr)
            SFR_R_ADDR: r_next.rdata = {8'h00, r_reg.a};
            SFR_R_LEN:  r_next.rdata = {16'h0000, r_reg.len};
            SFR_R_STAT: r_next.rdata = {30'h0, f_valid,
                                        r_reg.ph == H_RUN};
            SFR_R_DATA: r_next.rdata = {24'h0, f_valid ? f_data : 8'h00};
            default:    r_next.rdata = 32'h0;
         endcase
      end
      if (wr && addr == SFR_R_ADDR)
         r_next.a = wdata[23:0];
      if (wr && addr == SFR_R_LEN)
         r_next.len = wdata[15:0];
      if (r_reg.ph == H_IDLE) begin
         if (wr && addr == SFR_R_CTRL) begin
            // start a frame: select, present first bit
            r_next.ph = H_RUN;
            r_next.tx = {opc, r_reg.a, 8'h00};
            r_next.hdr = (md == SFR_M_READ || md == SFR_M_LOCK)
                         ? SFR_HDR_PLAIN : SFR_HDR_DUMMY; // RULE8 RULE13
            r_next.dual = md == SFR_M_DUAL;
            r_next.left = r_reg.len;
            r_next.done = r_reg.len == 16'h0;
            r_next.cs_n = 1'b0; // RULE1
            r_next.io0 = opc[7];
            r_next.io0_oe = 1'b1;
            r_next.cnt = 6'd0;
            r_next.rxn = 4'd0;
            r_next.div = 8'd0;
            r_next.sck = 1'b0;
         end
      end else if (!r_reg.push) begin
         // fifo back-pressure holds the serial clock
         r_next.div = r_reg.div + 8'd1;
         if (r_reg.div == 8'(HALF - 1)) begin
            r_next.div = 8'd0;
            r_next.sck = ~r_reg.sck;
            if (!r_reg.sck) begin
               if (r_reg.cnt < r_reg.hdr) begin
                  r_next.cnt = r_reg.cnt + 6'd1;
               end else if (!r_reg.done) begin
                  if (r_reg.dual) begin
                     r_next.rx = {r_reg.rx[5:0], r_reg.i1_f,
                                  r_reg.i0_f}; // RULE9
                     r_next.rxn = r_reg.rxn + 4'd2;
                  end else begin
                     r_next.rx = {r_reg.rx[6:0], r_reg.i1_f};
                     r_next.rxn = r_reg.rxn + 4'd1;
                  end
                  if (r_next.rxn == 4'd8) begin
                     r_next.rxn = 4'd0;
                     r_next.rxb = r_next.rx;
                     r_next.push = 1'b1;
                     r_next.left = r_reg.left - 16'd1;
                     r_next.done = r_reg.left == 16'd1;
                  end
               end
            end else begin
               if (r_reg.cnt < r_reg.hdr) begin
                  r_next.tx = {r_reg.tx[38:0], 1'b0};
                  r_next.io0 = r_reg.tx[38];
               end else begin
                  r_next.io0_oe = 1'b0;
                  if (r_reg.done) begin
                     r_next.cs_n = 1'b1; // RULE6
                     r_next.ph = H_IDLE;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.cs_n <= 1'b1;
         r_reg.ph <= H_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign lk.sck = r_reg.sck;
   assign lk.cs_n = r_reg.cs_n;
   assign lk.h_io0 = r_reg.io0;
   assign lk.h_io0_oe = r_reg.io0_oe;
   assign rdata = r_reg.rdata;
endmodule : sfr_host
`default_nettype wire

// file: shared/sfr_link_if.sv
// serial link between host controller and flash read path
`timescale 1ns/1ps
`default_nettype none
interface sfr_link_if;
   logic sck;
   logic cs_n;
   logic h_io0;
   logic h_io0_oe;
   logic d_io0;
   logic d_io0_oe;
   logic d_io1;
   logic d_io1_oe;
   logic io0;
   logic io1;
   // resolved line levels, undriven reads low
   assign io0 = d_io0_oe ? d_io0 : (h_io0_oe ? h_io0 : 1'b0);
   assign io1 = d_io1_oe ? d_io1 : 1'b0;
   modport dev (input sck, cs_n, io0,
                output d_io0, d_io0_oe, d_io1, d_io1_oe);
   modport host (output sck, cs_n, h_io0, h_io0_oe,
                 input io0, io1);
endinterface : sfr_link_if
`default_nettype wire

// file: shared/sfr_pkg.sv
// shared constants and types for the serial flash read path
// Summary of operation
// RULE1: read: opcode, 24-bit address, sampled on rising clock
// RULE2: read data shifted out on falling clock
// RULE3: any start address accepted for array reads
// RULE4: address increments per byte, wraps to zero
// RULE5: top address bit ignored for array reads
// RULE6: chip select high ends command, outputs released
// RULE7: reads rejected while internal cycle is busy
// RULE8: fast and dual reads add one dummy byte
// RULE9: dual read drives two bits per falling edge
// RULE10: lock read selects sector, shifts its lock byte
// RULE11: lock-down bit freezes lock bits until reset
// RULE12: write-lock bit refuses writes in that sector
// RULE13: one-time area read: address, dummy, incrementing bytes
// RULE14: one-time area repeats 65th byte, no wrap
// RULE15: one-time area ignores address bits 23 to 7
// RULE16: dual read msb first, line one higher bit
// RULE17: reserved lock bits read zero; opcodes are parameters
package sfr_pkg;
   // default opcodes, overridable per end
   localparam logic [7:0] SFR_OP_READ = 8'h03;
   localparam logic [7:0] SFR_OP_FAST = 8'h0b;
   localparam logic [7:0] SFR_OP_DUAL = 8'h3b;
   localparam logic [7:0] SFR_OP_LOCK = 8'he8;
   localparam logic [7:0] SFR_OP_OTP  = 8'h4b;
   // address layout
   localparam int SFR_SEC_MSB = 22;
   localparam int SFR_SEC_LSB = 16;
   localparam logic [6:0] SFR_OTP_LAST = 7'h40;
   localparam logic [7:0] SFR_LOCK_MASK = 8'h03;
   localparam int SFR_WLOCK_BIT = 0;
   localparam int SFR_LOCKDN_BIT = 1;
   localparam logic [5:0] SFR_HDR_PLAIN = 6'h20;
   localparam logic [5:0] SFR_HDR_DUMMY = 6'h28;
   // host register offsets
   localparam logic [4:0] SFR_R_CTRL = 5'h00;
   localparam logic [4:0] SFR_R_ADDR = 5'h04;
   localparam logic [4:0] SFR_R_LEN  = 5'h08;
   localparam logic [4:0] SFR_R_STAT = 5'h0c;
   localparam logic [4:0] SFR_R_DATA = 5'h10;
   // link clock timing
   localparam int SFR_CLK_NS = 8;
   localparam int SFR_SCK_NS = 160;
   localparam int SFR_HALF_CYC = SFR_SCK_NS / 2 / SFR_CLK_NS;
   localparam int SFR_FIFO_DEPTH = 32;
   typedef enum logic [2:0] {
      SFR_M_READ, SFR_M_FAST, SFR_M_DUAL, SFR_M_LOCK, SFR_M_OTP
   } sfr_mode_type;
endpackage : sfr_pkg

// file: verif/sfr_link_props.sv
// concurrent checks on the serial link between host and flash ends
`timescale 1ns/1ps
`default_nettype none
module sfr_link_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic h_io0,
   input wire logic h_io0_oe,
   input wire logic d_io0,
   input wire logic d_io0_oe,
   input wire logic d_io1,
   input wire logic d_io1_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // link clock rests low whenever no device is selected
   property p_sck_idle;
      cs_n |-> !sck;
   endproperty
   a_sck_idle: assert property (p_sck_idle)
      else $error("serial clock active while deselected");

   // each clock phase lasts at least eight system cycles
   property p_hi_half;
      $rose(sck) |-> sck [*8];
   endproperty
   a_hi_half: assert property (p_hi_half)
      else $error("serial clock high phase too short");

   property p_lo_half;
      $fell(sck) |-> !sck [*8];
   endproperty
   a_lo_half: assert property (p_lo_half)
      else $error("serial clock low phase too short");

   // opcode bit is on the line before the first rising clock
   property p_cmd_drive;
      $fell(cs_n) |-> h_io0_oe && !sck;
   endproperty
   a_cmd_drive: assert property (p_cmd_drive)
      else $error("frame started without host driving the line");

   // host bits move only while the clock is low
   property p_host_shift;
      h_io0_oe && $past(h_io0_oe) && $changed(h_io0) |-> !sck;
   endproperty
   a_host_shift: assert property (p_host_shift)
      else $error("host data changed while clock high");

   // device waits until the header is over before driving
   property p_one_driver;
      h_io0_oe |-> !(d_io0_oe || d_io1_oe);
   endproperty
   a_one_driver: assert property (p_one_driver)
      else $error("device drives during the header");

   // device data moves only after a falling clock
   property p_dev_shift;
      d_io1_oe && $past(d_io1_oe) && $changed(d_io1) |-> !sck;
   endproperty
   a_dev_shift: assert property (p_dev_shift)
      else $error("device data changed while clock high");

   property p_dual_shift;
      d_io0_oe && $past(d_io0_oe) && $changed(d_io0) |-> !sck;
   endproperty
   a_dual_shift: assert property (p_dual_shift)
      else $error("second data line changed while clock high");

   // line zero is only driven by the device together with line one
   property p_dual_pair;
      d_io0_oe |-> d_io1_oe;
   endproperty
   a_dual_pair: assert property (p_dual_pair)
      else $error("line zero driven without line one");

   // deselect releases both lines within a few cycles
   property p_release;
      $rose(cs_n) |-> ##[0:6] !(d_io0_oe || d_io1_oe);
   endproperty
   a_release: assert property (p_release)
      else $error("device kept driving after deselect");

   property p_quiet;
      cs_n [*7] |-> !(d_io0_oe || d_io1_oe);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("device drives while deselected");
endmodule : sfr_link_props
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench joining the host and flash ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb_top import sfr_pkg::*; ;
   logic        clk;
   logic        resetn;
   logic        busy;
   logic [22:0] mem_addr;
   logic [7:0]  mem_rdata;
   logic        lock_we;
   logic [6:0]  lock_sector;
   logic [7:0]  lock_wdata;
   logic [6:0]  prot_sector;
   logic        prot_deny;
   logic        otp_we;
   logic [6:0]  otp_idx;
   logic [7:0]  otp_wdata;
   logic [4:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic [31:0] v;
   logic [2:0]  cur_mode;
   logic [23:0] cur_addr;
   logic [7:0]  lock_exp;
   logic        refused;
   int          failures;
   int          checks;

   sfr_link_if lk ();
   sfr_dev sfr_dev_i (.clk(clk), .resetn(resetn), .lk(lk), .busy(busy),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .lock_we(lock_we),
      .lock_sector(lock_sector), .lock_wdata(lock_wdata),
      .prot_sector(prot_sector), .prot_deny(prot_deny), .otp_we(otp_we),
      .otp_idx(otp_idx), .otp_wdata(otp_wdata));
   sfr_host sfr_host_i (.clk(clk), .resetn(resetn), .lk(lk), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   sfr_link_props sfr_link_props_i (.clk(clk), .resetn(resetn), .sck(lk.sck),
      .cs_n(lk.cs_n), .h_io0(lk.h_io0), .h_io0_oe(lk.h_io0_oe),
      .d_io0(lk.d_io0), .d_io0_oe(lk.d_io0_oe), .d_io1(lk.d_io1),
      .d_io1_oe(lk.d_io1_oe));

   // array contents are a fixed mix of the address bits
   function automatic logic [7:0] memf(input logic [22:0] a);
      return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]} ^ 8'h5a;
   endfunction : memf

   function automatic logic [7:0] exp_byte(input int i);
      if (refused) return 8'h00;
      case (cur_mode)
         3'd3: return lock_exp;
         3'd4: return 8'h00;
         default: return memf(cur_addr[22:0] + 23'(i));
      endcase
   endfunction : exp_byte

   // array answers one cycle after the address
   always @(posedge clk) mem_rdata <= memf(mem_addr);

   // clock generator
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : reg_rd

   task automatic start(input logic [2:0] m, input logic [23:0] a, int n);
      cur_mode = m;
      cur_addr = a;
      reg_wr(SFR_R_ADDR, {8'h00, a});
      reg_wr(SFR_R_LEN, 32'(n));
      reg_wr(SFR_R_CTRL, {29'h0, m});
   endtask : start

   task automatic wait_idle();
      logic [31:0] s;
      s = 32'h1;
      for (int k = 0; k < 12000 && s[0] !== 1'b0; k++) reg_rd(SFR_R_STAT, s);
      chk("frame end", {31'h0, s[0]}, 32'h0);
   endtask : wait_idle

   task automatic drain(input int first, input int n);
      logic [31:0] d;
      for (int i = first; i < first + n; i++) begin
         reg_rd(SFR_R_DATA, d);
         chk("read byte", d, {24'h0, exp_byte(i)});
      end
   endtask : drain

   task automatic frame(input logic [2:0] m, input logic [23:0] a, int n);
      start(m, a, n);
      wait_idle();
      drain(0, n);
   endtask : frame

   task automatic lock_set(input logic [6:0] s, input logic [7:0] d);
      @(posedge clk);
      lock_we <= 1'b1;
      lock_sector <= s;
      lock_wdata <= d;
      @(posedge clk);
      lock_we <= 1'b0;
   endtask : lock_set

   task automatic prot(input logic [6:0] s, input logic e);
      @(posedge clk);
      prot_sector <= s;
      repeat (2) @(posedge clk);
      #1 chk("write lock", {31'h0, prot_deny}, {31'h0, e});
   endtask : prot

   task automatic test_done();
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   // watchdog against a hung handshake, well above the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      test_done();
   end

   // main sequence
   initial begin
      {failures, checks} = '0;
      {refused, lock_exp, cur_mode, cur_addr} = '0;
      {resetn, busy, lock_we, otp_we, wr, rd} = '0;
      {lock_sector, lock_wdata, prot_sector, otp_idx, otp_wdata} = '0;
      {addr, wdata} = '0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // one-time area programmed to known zeros
      for (int i = 0; i < 65; i++) begin
         @(posedge clk);
         otp_we <= 1'b1;
         otp_idx <= 7'(i);
      end
      @(posedge clk);
      otp_we <= 1'b0;
      reg_rd(5'h1c, v);
      chk("unmapped", v, 32'h0);
      reg_rd(SFR_R_DATA, v);
      chk("empty data", v, 32'h0);
      // long read across the top, fifo fills and stalls the link
      start(3'd0, 24'hfffff0, 34);
      repeat (8000) @(posedge clk);
      reg_rd(SFR_R_STAT, v);
      chk("stalled status", v, 32'h3);
      drain(0, 32);
      wait_idle();
      drain(32, 2);
      frame(3'd1, 24'h123456, 3);
      frame(3'd2, 24'h7ffffe, 3);
      // sector lock bytes, lock-down freezes them
      lock_exp = 8'h03;
      lock_set(7'd5, 8'hff);
      prot(7'd5, 1'b1);
      frame(3'd3, {1'b1, 7'd5, 16'habcd}, 2);
      lock_set(7'd5, 8'h00);
      frame(3'd3, {1'b0, 7'd5, 16'h0000}, 1);
      prot(7'd6, 1'b0);
      lock_set(7'd6, 8'h01);
      prot(7'd6, 1'b1);
      lock_set(7'd6, 8'h00);
      prot(7'd6, 1'b0);
      frame(3'd4, 24'hffffbe, 5);
      // reads refused while an internal cycle runs
      @(posedge clk);
      busy <= 1'b1;
      refused = 1'b1;
      frame(3'd0, 24'h000123, 2);
      @(posedge clk);
      busy <= 1'b0;
      refused = 1'b0;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
